// file: core/cpm_pkg.sv
// package: register map, field positions and reset values of the pin mux config block
package cpm_pkg;
   localparam int          CPM_AW              = 8;
   localparam logic [7:0]  CPM_OFF_GLOBAL      = 8'h21;
   localparam logic [7:0]  CPM_OFF_ROUTE_B     = 8'h22;
   localparam logic [7:0]  CPM_OFF_ROUTE_C     = 8'h23;
   // global_device_control fields
   localparam int          CPM_GC_LOCK         = 7;
   localparam int          CPM_GC_RESET_TRIG   = 1;
   localparam int          CPM_GC_ENABLE       = 0;
   localparam logic [7:0]  CPM_GC_RESET        = 8'h11;
   localparam logic [7:0]  CPM_GC_RSVD_MASK    = 8'h7C;
   // pin_route_select_b fields
   localparam int          CPM_B_WDOG          = 7;
   localparam int          CPM_B_KBMS          = 5;
   localparam int          CPM_B_SFAIL         = 4;
   localparam int          CPM_B_FMTR          = 3;
   localparam int          CPM_B_FSEL          = 2;
   localparam int          CPM_B_PRN           = 1;
   localparam int          CPM_B_CLKRUN        = 0;
   localparam logic [7:0]  CPM_B_RESET         = 8'h20;
   localparam logic [7:0]  CPM_B_WR_MASK       = 8'hBF;
   // pin_route_select_c fields
   localparam int          CPM_C_SLPST         = 7;
   localparam int          CPM_C_CIRQ          = 6;
   localparam int          CPM_C_MIRQ          = 5;
   localparam int          CPM_C_PBOUT         = 4;
   localparam int          CPM_C_PBIN          = 3;
   localparam int          CPM_C_SBIN          = 2;
   localparam int          CPM_C_LED2          = 1;
   localparam int          CPM_C_LED1          = 0;
   localparam logic [7:0]  CPM_C_RESET_LOW     = 8'h00;
   localparam logic [7:0]  CPM_ZERO8           = 8'h00;
endpackage

// file: core/cpm_pin_mux.sv
// module: global enable, host reset trigger and pin routing registers
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// [R01] writing one pulses host reset; reads zero
// [R02] reset trigger ignores the lock bit
// [R03] enable one lets each device run
// [R04] enable zero forces every device off
// [R05] b7 routes watchdog output versus general output
// [R06] b5 routes keyboard/mouse lines, default keyboard
// [R07] b4 routes supply-fail input versus general input
// [R08] b3 routes floppy motor versus keyboard line
// [R09] b2 routes floppy select versus keyboard line
// [R10] b1 keyboard line forces printer disable low
// [R11] b0 routes clock-run versus general port
// [R12] c7 sleep outputs; else internal states high
// [R13] c7 resets to external state choice input
// [R14] c6 routes control interrupt output
// [R15] c5 routes management interrupt output
// [R16] c4 zero routes power-button output
// [R17] c3 one holds power-button input high
// [R18] c2 zero holds sleep-button input high
// [R19] c1/c0 route the indicator outputs
// [R20] lock blocks writes except enable, trigger
// [R21] reserved bits fixed; routing follows registers
module cpm_pin_mux #(
   parameter int N_DEV = 8
) (
   input  wire logic                      mclk,
   input  wire logic                      srst,
   input  wire logic [cpm_pkg::CPM_AW-1:0] addr,
   input  wire logic [7:0]                wdata,
   input  wire logic                      wr_stb,
   input  wire logic                      rd_stb,
   output logic      [7:0]                rdata,
   input  wire logic                      external_state_choice,
   input  wire logic [N_DEV-1:0]          dev_enable_req,
   output logic      [N_DEV-1:0]          dev_enable,
   output logic                           host_soft_reset_trigger,
   output logic      [7:0]                route_b,
   output logic      [7:0]                route_c,
   output logic                           printer_port_disable_in,
   output logic                           suspend_ram_state_int,
   output logic                           soft_off_state_int,
   output logic                           power_button_in,
   output logic                           sleep_button_in,
   input  wire logic                      printer_port_disable_pin,
   input  wire logic                      power_button_pin,
   input  wire logic                      sleep_button_pin,
   input  wire logic                      wake_suspend_ram_state,
   input  wire logic                      wake_soft_off_state
);
   import cpm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic       all_devices_enable;
   logic       mux_config_lock;
   logic [7:0] pin_route_select_b;
   logic [7:0] pin_route_select_c;
   logic       wr_gc;
   logic       wr_b;
   logic       wr_c;
   logic       next_sleep_route;

   assign wr_gc = wr_stb && (addr == CPM_OFF_GLOBAL);
   assign wr_b  = wr_stb && (addr == CPM_OFF_ROUTE_B) && !mux_config_lock; // R20
   assign wr_c  = wr_stb && (addr == CPM_OFF_ROUTE_C) && !mux_config_lock; // R20

   ////////////////////////////////////////////////////////////////////////////
   // global device control
   always_ff @(posedge mclk) begin
      if (srst) begin
         all_devices_enable <= CPM_GC_RESET[CPM_GC_ENABLE];
      end else if (wr_gc) begin
         all_devices_enable <= wdata[CPM_GC_ENABLE]; // R03 R04
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mux_config_lock <= CPM_GC_RESET[CPM_GC_LOCK];
      end else if (wr_gc && wdata[CPM_GC_LOCK]) begin
         mux_config_lock <= 1'b1; // R20
      end
   end

   // one-cycle pulse, never stored as readable state
   always_ff @(posedge mclk) begin
      if (srst) begin
         host_soft_reset_trigger <= 1'b0;
      end else begin
         host_soft_reset_trigger <= wr_gc && wdata[CPM_GC_RESET_TRIG]; // R01 R02
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         dev_enable <= '0;
      end else begin
         dev_enable <= all_devices_enable ? dev_enable_req : '0; // R03 R04
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // route registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_route_select_b <= CPM_B_RESET;
      end else if (wr_b) begin
         pin_route_select_b <= (wdata & CPM_B_WR_MASK) | (CPM_B_RESET & ~CPM_B_WR_MASK); // R21
      end
   end

   // reset keeps the strap low; the captured choice is loaded the cycle after release
   logic rst_d;
   always_ff @(posedge mclk) begin
      if (srst) begin
         rst_d <= 1'b1;
      end else begin
         rst_d <= 1'b0;
      end
   end

   assign next_sleep_route = rst_d ? external_state_choice : pin_route_select_c[CPM_C_SLPST];

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_route_select_c <= CPM_C_RESET_LOW;
      end else if (rst_d) begin
         pin_route_select_c <= {external_state_choice, CPM_C_RESET_LOW[6:0]}; // R13
      end else if (wr_c) begin
         pin_route_select_c <= wdata;
      end else begin
         pin_route_select_c[CPM_C_SLPST] <= next_sleep_route;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // routing outputs: registered copies of the select registers and internal forcing
   always_ff @(posedge mclk) begin
      if (srst) begin
         route_b <= CPM_B_RESET;
         route_c <= CPM_C_RESET_LOW;
      end else begin
         route_b <= wr_b ? ((wdata & CPM_B_WR_MASK) | (CPM_B_RESET & ~CPM_B_WR_MASK))
                         : pin_route_select_b; // R05 R06 R07 R08 R09 R11 R21
         route_c <= rst_d ? {external_state_choice, CPM_C_RESET_LOW[6:0]}
                  : wr_c  ? wdata : pin_route_select_c; // R14 R15 R16 R19 R21
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         printer_port_disable_in <= 1'b0;
         suspend_ram_state_int   <= 1'b1;
         soft_off_state_int      <= 1'b1;
         power_button_in         <= 1'b1;
         sleep_button_in         <= 1'b1;
      end else begin
         printer_port_disable_in <= route_b[CPM_B_PRN] ? 1'b0 : printer_port_disable_pin; // R10
         suspend_ram_state_int   <= route_c[CPM_C_SLPST] ? wake_suspend_ram_state : 1'b1; // R12
         soft_off_state_int      <= route_c[CPM_C_SLPST] ? wake_soft_off_state : 1'b1; // R12
         power_button_in         <= route_c[CPM_C_PBIN] ? 1'b1 : power_button_pin; // R17
         sleep_button_in         <= route_c[CPM_C_SBIN] ? sleep_button_pin : 1'b1; // R18
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port: data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata <= CPM_ZERO8;
      end else if (rd_stb) begin
         unique case (addr)
            CPM_OFF_GLOBAL:  rdata <= {mux_config_lock, 1'b0, CPM_GC_RESET[5:2], 1'b0,
                                       all_devices_enable}; // R01 R21
            CPM_OFF_ROUTE_B: rdata <= pin_route_select_b;
            CPM_OFF_ROUTE_C: rdata <= pin_route_select_c;
            default:         rdata <= CPM_ZERO8;
         endcase
      end else begin
         rdata <= CPM_ZERO8;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_trig_write;
      wr_stb && addr == CPM_OFF_GLOBAL && wdata[CPM_GC_RESET_TRIG];
   endsequence

   AST_TRIG_PULSE: assert property (@(posedge mclk) disable iff (srst) // R01
      s_trig_write |=> host_soft_reset_trigger)
      else $error("host reset trigger not raised");

   AST_TRIG_LOCKED: assert property (@(posedge mclk) disable iff (srst) // R02
      (mux_config_lock && wr_stb && addr == CPM_OFF_GLOBAL && wdata[CPM_GC_RESET_TRIG])
      |=> host_soft_reset_trigger)
      else $error("host reset trigger blocked by lock");

   AST_TRIG_READ0: assert property (@(posedge mclk) disable iff (srst) // R01
      (rd_stb && addr == CPM_OFF_GLOBAL) |=> !rdata[CPM_GC_RESET_TRIG])
      else $error("trigger bit read nonzero");

   AST_DEV_OFF: assert property (@(posedge mclk) disable iff (srst) // R04
      (wr_stb && addr == CPM_OFF_GLOBAL && !wdata[CPM_GC_ENABLE]) |=> ##1 dev_enable == '0)
      else $error("devices not forced off");

   AST_DEV_ON: assert property (@(posedge mclk) disable iff (srst) // R03
      (!srst && all_devices_enable) |=> dev_enable == $past(dev_enable_req))
      else $error("device enable not following request");

   AST_LOCK_B: assert property (@(posedge mclk) disable iff (srst) // R20
      (mux_config_lock && wr_stb && addr == CPM_OFF_ROUTE_B) |=> $stable(pin_route_select_b))
      else $error("locked route b changed");

   AST_RSVD_B: assert property (@(posedge mclk) disable iff (srst) // R21
      !pin_route_select_b[6])
      else $error("reserved bit of route b set");

   AST_PRN_FORCE: assert property (@(posedge mclk) disable iff (srst) // R10
      route_b[CPM_B_PRN] |=> !printer_port_disable_in)
      else $error("printer disable not forced low");

   AST_SLEEP_HIGH: assert property (@(posedge mclk) disable iff (srst) // R12
      !route_c[CPM_C_SLPST] |=> suspend_ram_state_int && soft_off_state_int)
      else $error("sleep states not held high");

   AST_STRAP: assert property (@(posedge mclk) disable iff (srst) // R13
      (!srst && rst_d) |=> pin_route_select_c[CPM_C_SLPST] == $past(external_state_choice))
      else $error("sleep route not loaded from choice");

   AST_PB_HIGH: assert property (@(posedge mclk) disable iff (srst) // R17
      route_c[CPM_C_PBIN] |=> power_button_in)
      else $error("power button input not held high");

   AST_SB_HIGH: assert property (@(posedge mclk) disable iff (srst) // R18
      !route_c[CPM_C_SBIN] |=> sleep_button_in)
      else $error("sleep button input not held high");

   sequence s_wr_route_b;
      wr_stb && addr == CPM_OFF_ROUTE_B && !mux_config_lock;
   endsequence

   sequence s_wr_route_c;
      wr_stb && addr == CPM_OFF_ROUTE_C && !mux_config_lock && !rst_d;
   endsequence

   sequence s_gc_write;
      wr_stb && addr == CPM_OFF_GLOBAL;
   endsequence

   sequence s_gc_read;
      rd_stb && addr == CPM_OFF_GLOBAL;
   endsequence

   sequence s_rd_route_b;
      rd_stb && addr == CPM_OFF_ROUTE_B;
   endsequence

   sequence s_rd_route_c;
      rd_stb && addr == CPM_OFF_ROUTE_C;
   endsequence

   sequence s_rd_unmapped;
      rd_stb && addr != CPM_OFF_GLOBAL && addr != CPM_OFF_ROUTE_B && addr != CPM_OFF_ROUTE_C;
   endsequence

   // write, lock and mirror checks
   AST_TRIG_ONLY: assert property (@(posedge mclk) disable iff (srst) // R01
      !(wr_stb && addr == CPM_OFF_GLOBAL && wdata[CPM_GC_RESET_TRIG]) |=> !host_soft_reset_trigger)
      else $error("host reset trigger without a write");

   AST_LOCK_SET: assert property (@(posedge mclk) disable iff (srst) // R20
      (s_gc_write ##0 wdata[CPM_GC_LOCK]) |=> mux_config_lock)
      else $error("lock bit not set by write");

   AST_LOCK_STICKY: assert property (@(posedge mclk) disable iff (srst) // R20
      mux_config_lock |=> mux_config_lock)
      else $error("lock bit cleared without reset");

   AST_EN_WRITE: assert property (@(posedge mclk) disable iff (srst) // R03 R04 R20
      s_gc_write |=> all_devices_enable == $past(wdata[CPM_GC_ENABLE]))
      else $error("global enable write not taken");

   AST_DEV_HOLD_OFF: assert property (@(posedge mclk) disable iff (srst) // R04
      (!srst && !all_devices_enable) |=> dev_enable == '0)
      else $error("device enabled while global enable low");

   AST_LOCK_C: assert property (@(posedge mclk) disable iff (srst) // R20
      (mux_config_lock && wr_stb && addr == CPM_OFF_ROUTE_C) |=> $stable(pin_route_select_c))
      else $error("locked route c changed");

   AST_LOCK_OUT_B: assert property (@(posedge mclk) disable iff (srst) // R20
      (mux_config_lock && wr_stb && addr == CPM_OFF_ROUTE_B) |=> $stable(route_b))
      else $error("locked route b output changed");

   AST_LOCK_OUT_C: assert property (@(posedge mclk) disable iff (srst) // R20
      (mux_config_lock && wr_stb && addr == CPM_OFF_ROUTE_C) |=> $stable(route_c))
      else $error("locked route c output changed");

   AST_ROUTE_B_WR: assert property (@(posedge mclk) disable iff (srst) // R05 R06 R07 R08 R09 R11
      s_wr_route_b |=> route_b == {$past(wdata[7]), 1'b0, $past(wdata[5:0])})
      else $error("route b output not the written value");

   AST_ROUTE_C_WR: assert property (@(posedge mclk) disable iff (srst) // R14 R15 R16 R19
      s_wr_route_c |=> route_c == $past(wdata))
      else $error("route c output not the written value");

   AST_ROUTE_B_NOW: assert property (@(posedge mclk) disable iff (srst) // R21
      route_b == pin_route_select_b)
      else $error("route b output lags its register");

   AST_ROUTE_C_NOW: assert property (@(posedge mclk) disable iff (srst) // R21
      route_c == pin_route_select_c)
      else $error("route c output lags its register");

   AST_RSVD_OUT_B: assert property (@(posedge mclk) disable iff (srst) // R21
      !route_b[6])
      else $error("reserved bit of route b output set");

   AST_STRAP_OUT: assert property (@(posedge mclk) disable iff (srst) // R13
      (!srst && rst_d) |=> route_c[CPM_C_SLPST] == $past(external_state_choice))
      else $error("sleep route output not loaded from choice");

   AST_C_HOLD: assert property (@(posedge mclk) disable iff (srst) // R13 R21
      (!rst_d && !(wr_stb && addr == CPM_OFF_ROUTE_C)) |=> $stable(pin_route_select_c))
      else $error("route c changed without a write");

   AST_B_HOLD: assert property (@(posedge mclk) disable iff (srst) // R21
      !(wr_stb && addr == CPM_OFF_ROUTE_B) |=> $stable(pin_route_select_b))
      else $error("route b changed without a write");

   // read port and internal forcing checks
   AST_RD_B: assert property (@(posedge mclk) disable iff (srst) // R21
      s_rd_route_b |=> rdata == $past(pin_route_select_b))
      else $error("route b read wrong");

   AST_RD_C: assert property (@(posedge mclk) disable iff (srst) // R19 R21
      s_rd_route_c |=> rdata == $past(pin_route_select_c))
      else $error("route c read wrong");

   AST_RD_GC: assert property (@(posedge mclk) disable iff (srst) // R01 R21
      s_gc_read |=> rdata[7] == $past(mux_config_lock) && rdata[5:2] == CPM_GC_RESET[5:2]
                    && !rdata[6] && rdata[0] == $past(all_devices_enable))
      else $error("global control read wrong");

   AST_RD_UNMAPPED: assert property (@(posedge mclk) disable iff (srst) // R21
      s_rd_unmapped |=> rdata == CPM_ZERO8)
      else $error("unmapped read nonzero");

   AST_RD_IDLE: assert property (@(posedge mclk) disable iff (srst) // R21
      !rd_stb |=> rdata == CPM_ZERO8)
      else $error("read data outside read cycle");

   AST_PRN_PASS: assert property (@(posedge mclk) disable iff (srst) // R10
      (!srst && !route_b[CPM_B_PRN])
         |=> printer_port_disable_in == $past(printer_port_disable_pin))
      else $error("printer disable not passed through");

   AST_SLEEP_PASS: assert property (@(posedge mclk) disable iff (srst) // R12
      (!srst && route_c[CPM_C_SLPST])
         |=> suspend_ram_state_int == $past(wake_suspend_ram_state)
             && soft_off_state_int == $past(wake_soft_off_state))
      else $error("sleep states not passed through");

   AST_PB_PASS: assert property (@(posedge mclk) disable iff (srst) // R17
      (!srst && !route_c[CPM_C_PBIN]) |=> power_button_in == $past(power_button_pin))
      else $error("power button input not passed through");

   AST_SB_PASS: assert property (@(posedge mclk) disable iff (srst) // R18
      (!srst && route_c[CPM_C_SBIN]) |=> sleep_button_in == $past(sleep_button_pin))
      else $error("sleep button input not passed through");
endmodule

`default_nettype wire

// file: tb/cpm_pin_mux_tb_top.sv
// testbench: register access, lock, trigger, global enable and pin routing of the pin mux block
`timescale 1ns/100ps
`default_nettype none
module cpm_pin_mux_tb_top;
   import cpm_pkg::*;
   logic        mclk, srst, wr_stb, rd_stb, esc, trig, rd_d;
   logic        ppd_pin, pb_pin, sb_pin, s3_wk, s5_wk;
   logic        ppd_in, s3_int, s5_int, pb_in, sb_in;
   logic [7:0]  addr, wdata, rdata, route_b, route_c, dev_req, dev_enable, db, dc;
   logic [7:0]  exp_q[$];
   int          err_count = 0;
   int          checks_done = 0;
   int unsigned seed_v;

   cpm_pin_mux #(.N_DEV(8)) u_dut (
      .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .external_state_choice(esc),
      .dev_enable_req(dev_req), .dev_enable(dev_enable), .host_soft_reset_trigger(trig),
      .route_b(route_b), .route_c(route_c), .printer_port_disable_in(ppd_in),
      .suspend_ram_state_int(s3_int), .soft_off_state_int(s5_int),
      .power_button_in(pb_in), .sleep_button_in(sb_in),
      .printer_port_disable_pin(ppd_pin), .power_button_pin(pb_pin),
      .sleep_button_pin(sb_pin), .wake_suspend_ram_state(s3_wk),
      .wake_soft_off_state(s5_wk));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_stb <= 1'b1;
      addr   <= a;
      wdata  <= d;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      rd_stb <= 1'b1;
      addr   <= a;
      exp_q.push_back(e);
      @(posedge mclk);
      rd_stb <= 1'b0;
   endtask
   task automatic do_reset(input logic e);
      esc  <= e;
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // read data stand only in the cycle after the strobe
   always @(posedge mclk) rd_d <= rd_stb & ~srst;
   always @(negedge mclk) begin
      if (rd_d) begin
         if (exp_q.size() == 0) chk(rdata, 8'hEE);
         else chk(rdata, exp_q.pop_front());
      end
   end
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {srst, wr_stb, rd_stb, esc} = 4'h8;
      {ppd_pin, pb_pin, sb_pin, s3_wk, s5_wk} = 5'h00;
      {addr, wdata, dev_req} = 24'h00_0000;
      seed_v = $urandom(82199);
      do_reset(1'b1);
      #1 chk(route_c, 8'h80);
      rd(CPM_OFF_ROUTE_C, 8'h80);
      rd(CPM_OFF_GLOBAL, CPM_GC_RESET);
      rd(CPM_OFF_ROUTE_B, CPM_B_RESET);
      wr(CPM_OFF_GLOBAL, 8'h03);
      #1 chk(trig, 1'b1);
      @(posedge mclk);
      #1 chk(trig, 1'b0);
      rd(CPM_OFF_GLOBAL, CPM_GC_RESET);
      dev_req <= 8'($urandom) | 8'h01;
      wr(CPM_OFF_GLOBAL, 8'h00);
      repeat (2) @(posedge mclk);
      #1 chk(dev_enable, 8'h00);
      rd(CPM_OFF_GLOBAL, 8'h10);
      wr(CPM_OFF_GLOBAL, 8'h01);
      wr(8'h30, 8'hFF);
      rd(8'h30, CPM_ZERO8);
      for (int i = 0; i < 12; i++) begin
         db = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         dc = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         {ppd_pin, pb_pin, sb_pin, s3_wk, s5_wk} <= 5'($urandom);
         dev_req <= 8'($urandom);
         wr(CPM_OFF_ROUTE_B, db);
         wr(CPM_OFF_ROUTE_C, dc);
         repeat (2) @(posedge mclk);
         #1 chk(route_b, db & CPM_B_WR_MASK);
         chk(route_c, dc);
         chk(ppd_in, db[CPM_B_PRN] ? 1'b0 : ppd_pin);
         chk(s3_int, dc[CPM_C_SLPST] ? s3_wk : 1'b1);
         chk(s5_int, dc[CPM_C_SLPST] ? s5_wk : 1'b1);
         chk(pb_in, dc[CPM_C_PBIN] ? 1'b1 : pb_pin);
         chk(sb_in, dc[CPM_C_SBIN] ? sb_pin : 1'b1);
         chk(dev_enable, dev_req);
         rd(CPM_OFF_ROUTE_B, db & CPM_B_WR_MASK);
         rd(CPM_OFF_ROUTE_C, dc);
      end
      // locked: route writes dropped, trigger and enable still take effect
      wr(CPM_OFF_GLOBAL, 8'h81);
      wr(CPM_OFF_ROUTE_B, ~db);
      wr(CPM_OFF_ROUTE_C, ~dc);
      rd(CPM_OFF_ROUTE_B, db & CPM_B_WR_MASK);
      rd(CPM_OFF_ROUTE_C, dc);
      wr(CPM_OFF_GLOBAL, 8'h02);
      #1 chk(trig, 1'b1);
      repeat (2) @(posedge mclk);
      #1 chk(dev_enable, 8'h00);
      rd(CPM_OFF_GLOBAL, 8'h90);
      do_reset(1'b0);
      rd(CPM_OFF_ROUTE_C, 8'h00);
      rd(CPM_OFF_GLOBAL, CPM_GC_RESET);
      repeat (3) @(posedge mclk);
      test_done();
   end
endmodule
`default_nettype wire
